// File: hdl/pgs_defines.svh
// register map, field positions and timing constants of the power-good selector
// How it works
// [R1] output a select bits 2..0 include boost, second buck, first buck; 0 masks
// [R2] output b select bits 5..0 include analog, monitors, boost, bucks; 0 masks
// [R3] output b select bit 6 lets thermal warning pull output b inactive
// [R4] select bit 7 set delays the rise to valid by 11 ms; clear means none
// [R5] fault register bits 6..0 per source; bit 7 reads zero
// [R6] fault bit sets when its selected source drives the output inactive
// [R7] writing one clears a fault bit only while its source is valid
// [R8] select and control reset values come from otp; fault bits reset to zero
// [R9] gating set: output follows fault register, inactive while any bit set
// [R10] output b has its own sticky fault register, same layout and clearing
// [R11] polarity bit 0 gives high when valid, 1 gives low when valid
// [R12] live status valid only when every selected source is good
`ifndef PGS_DEFINES_SVH
`define PGS_DEFINES_SVH

`define PGS_ADDR_CTRL      8'h17
`define PGS_ADDR_SEL_A     8'h18
`define PGS_ADDR_FAULT_A   8'h19
`define PGS_ADDR_SEL_B     8'h1a
`define PGS_ADDR_FAULT_B   8'h1b

`define PGS_SRC_N          7
`define PGS_SRC_THERMAL    6
`define PGS_SEL_DELAY      7
`define PGS_CTL_POL_A      0
`define PGS_CTL_GATE_A     2
`define PGS_CTL_POL_B      4
`define PGS_CTL_GATE_B     6

`define PGS_FAULT_RESET    7'h00
`define PGS_REG_RESET      8'h00
`define PGS_SYNC_RESET     7'h3f
`define PGS_RD_UNMAPPED    8'h00

`define PGS_RISE_DELAY_MS  11
`define PGS_CLK_HZ         50000000
`define PGS_MS_PER_S       1000
`define PGS_CNT_W          20

`endif

// File: hdl/pgs_pkg.sv
// types shared by the power-good selector modules
`include "pgs_defines.svh"
package pgs_pkg;

    typedef struct packed {
        logic [`PGS_SRC_N-1:0] fault;
        logic [`PGS_CNT_W-1:0] cnt;
        logic                  valid;
        logic                  pg;
    } pgs_chan_state_t;

    typedef struct packed {
        logic [`PGS_SRC_N-1:0] sync1;
        logic [`PGS_SRC_N-1:0] sync2;
        logic [7:0]            ctrl;
        logic [7:0]            sel_a;
        logic [7:0]            sel_b;
        logic                  loaded;
        logic [7:0]            rdata;
    } pgs_top_state_t;

endpackage

// File: hdl/pgs_chan_if.sv
// link between the register side and one power-good output channel
`timescale 1ns/1ns
`default_nettype none
`include "pgs_defines.svh"
interface pgs_chan_if;
    logic [7:0]            sel;
    logic [`PGS_SRC_N-1:0] good;
    logic [`PGS_SRC_N-1:0] clr;
    logic                  gating;
    logic                  pol;
    logic [`PGS_SRC_N-1:0] fault;
    logic                  pg;

    modport ctl  (output sel, good, clr, gating, pol, input fault, pg);
    modport chan (input sel, good, clr, gating, pol, output fault, pg);
endinterface
`default_nettype wire

// File: hdl/pgs_chan.sv
// one power-good output: sticky faults, live status, rise delay, polarity
`timescale 1ns/1ns
`default_nettype none
`include "pgs_defines.svh"
module pgs_chan #(
    parameter int unsigned DLY_CYC = `PGS_RISE_DELAY_MS * (`PGS_CLK_HZ / `PGS_MS_PER_S)
) (
    input  wire logic  clk_i,
    input  wire logic  arst_n_i,
    pgs_chan_if.chan   c
);
    // rise lands DLY_CYC edges after the undelayed rise would have
    localparam logic [`PGS_CNT_W-1:0] DLY_LAST = `PGS_CNT_W'(DLY_CYC);

    if (DLY_CYC < 2 || DLY_CYC >= (1 << `PGS_CNT_W)) begin : g_chk
        $error("pgs_chan: DLY_CYC out of range");
    end

    pgs_pkg::pgs_chan_state_t s_r;
    pgs_pkg::pgs_chan_state_t s_nxt;
    logic [`PGS_SRC_N-1:0]    set;
    logic                     live;
    logic                     raw;

    // source status and the valid decision
    always_comb begin
        set   = c.sel[`PGS_SRC_N-1:0] & ~c.good;                 // see [R6]
        live  = &(c.good | ~c.sel[`PGS_SRC_N-1:0]);              // see [R12]
        raw   = c.gating ? (s_r.fault == `PGS_FAULT_RESET && set == `PGS_FAULT_RESET) : live; // see [R9]
        s_nxt = s_r;
        s_nxt.fault = (s_r.fault & ~(c.clr & c.good)) | set;    // see [R7]
        if (!raw) begin
            s_nxt.valid = 1'b0;                                  // see [R12]
            s_nxt.cnt   = '0;
        end else if (s_r.valid) begin
            s_nxt.cnt = '0;
        end else if (!c.sel[`PGS_SEL_DELAY]) begin
            s_nxt.valid = 1'b1;                                  // see [R4]
        end else if (s_r.cnt == DLY_LAST) begin
            s_nxt.valid = 1'b1;                                  // see [R4]
            s_nxt.cnt   = '0;
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
        s_nxt.pg = s_nxt.valid ^ c.pol;                          // see [R11]
    end

    // channel state register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= '0;                                           // see [R8]
        end else begin
            s_r <= s_nxt;
        end
    end

    assign c.fault = s_r.fault;
    assign c.pg    = s_r.pg;

    property p_fault_set;
        @(posedge clk_i) disable iff (!arst_n_i)
        (set != '0) |=> ((s_r.fault & $past(set)) == $past(set));
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault bit not set"); // see [R6]

    property p_fault_clear;
        @(posedge clk_i) disable iff (!arst_n_i)
        ((c.clr & c.good & ~set) != '0) |=> ((s_r.fault & $past(c.clr & c.good & ~set)) == '0);
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault bit not cleared"); // see [R7]

    property p_fault_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> ((s_r.fault & $past(s_r.fault & ~(c.clr & c.good))) == $past(s_r.fault & ~(c.clr & c.good)));
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault bit lost"); // see [R7]

    property p_drop;
        @(posedge clk_i) disable iff (!arst_n_i)
        (!raw) |=> (!s_r.valid ##0 s_r.pg == $past(c.pol));
    endproperty
    a_drop: assert property (p_drop) else $error("output not dropped"); // see [R12]

    property p_gate;
        @(posedge clk_i) disable iff (!arst_n_i)
        (c.gating && s_r.fault != '0) |=> !s_r.valid;
    endproperty
    a_gate: assert property (p_gate) else $error("gated output valid with fault"); // see [R9]

    property p_rise_delay;
        @(posedge clk_i) disable iff (!arst_n_i)
        (raw && !s_r.valid && c.sel[`PGS_SEL_DELAY] && s_r.cnt == '0) |=> !s_r.valid;
    endproperty
    a_rise_delay: assert property (p_rise_delay) else $error("rise not delayed"); // see [R4]

    property p_no_delay;
        @(posedge clk_i) disable iff (!arst_n_i)
        (raw && !c.sel[`PGS_SEL_DELAY]) |=> s_r.valid;
    endproperty
    a_no_delay: assert property (p_no_delay) else $error("undelayed rise late"); // see [R4]

    property p_polarity;
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> (s_r.pg == (s_r.valid ^ $past(c.pol)));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong"); // see [R11]
endmodule
`default_nettype wire

// File: hdl/pgs_top.sv
// power-good source selection, fault latching and register port
`timescale 1ns/1ns
`default_nettype none
`include "pgs_defines.svh"
module pgs_top #(
    parameter int unsigned RISE_DELAY_CYC = `PGS_RISE_DELAY_MS * (`PGS_CLK_HZ / `PGS_MS_PER_S)
) (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       thermal_warning_i,
    input  wire logic       analog_supply_monitor_i,
    input  wire logic       external_monitor_two_i,
    input  wire logic       external_monitor_one_i,
    input  wire logic       boost_good_i,
    input  wire logic       buck_second_good_i,
    input  wire logic       buck_first_good_i,
    input  wire logic [7:0] otp_ctrl_i,
    input  wire logic [7:0] otp_sel_a_i,
    input  wire logic [7:0] otp_sel_b_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic [7:0]      reg_rdata_o,
    output logic            power_good_out_a_o,
    output logic            power_good_out_b_o
);
    // sync flops reset to pin idle levels, so release raises no false fault
    localparam pgs_pkg::pgs_top_state_t S_RESET =
        '{sync1: `PGS_SYNC_RESET, sync2: `PGS_SYNC_RESET, default: '0};

    pgs_pkg::pgs_top_state_t s_r;
    pgs_pkg::pgs_top_state_t s_nxt;
    logic [`PGS_SRC_N-1:0]   pins;
    logic [`PGS_SRC_N-1:0]   good;
    logic                    wr_ctrl;
    logic                    wr_sel_a;
    logic                    wr_sel_b;
    logic                    wr_fault_a;
    logic                    wr_fault_b;

    pgs_chan_if ch_a ();
    pgs_chan_if ch_b ();

    // raw monitor pins in source bit order
    assign pins = {thermal_warning_i, analog_supply_monitor_i, external_monitor_two_i,
                   external_monitor_one_i, boost_good_i, buck_second_good_i, buck_first_good_i};

    // thermal warning is active high, so its good level is inverted
    assign good = {~s_r.sync2[`PGS_SRC_THERMAL], s_r.sync2[`PGS_SRC_THERMAL-1:0]};

    // register write decode
    assign wr_ctrl    = reg_wr_i && reg_addr_i == `PGS_ADDR_CTRL;
    assign wr_sel_a   = reg_wr_i && reg_addr_i == `PGS_ADDR_SEL_A;
    assign wr_sel_b   = reg_wr_i && reg_addr_i == `PGS_ADDR_SEL_B;
    assign wr_fault_a = reg_wr_i && reg_addr_i == `PGS_ADDR_FAULT_A;
    assign wr_fault_b = reg_wr_i && reg_addr_i == `PGS_ADDR_FAULT_B;

    // next state: pin sync, otp load, register writes, read data
    always_comb begin
        s_nxt       = s_r;
        s_nxt.sync1 = pins;
        s_nxt.sync2 = s_r.sync1;
        if (!s_r.loaded) begin
            s_nxt.ctrl   = otp_ctrl_i;                           // see [R8]
            s_nxt.sel_a  = otp_sel_a_i;                          // see [R8]
            s_nxt.sel_b  = otp_sel_b_i;                          // see [R8]
            s_nxt.loaded = 1'b1;
        end else begin
            if (wr_ctrl) begin
                s_nxt.ctrl = reg_wdata_i;
            end
            if (wr_sel_a) begin
                s_nxt.sel_a = reg_wdata_i;                       // see [R1]
            end
            if (wr_sel_b) begin
                s_nxt.sel_b = reg_wdata_i;                       // see [R2] [R3] [R4]
            end
        end
        unique case (reg_addr_i)
            `PGS_ADDR_CTRL:    s_nxt.rdata = s_r.ctrl;
            `PGS_ADDR_SEL_A:   s_nxt.rdata = s_r.sel_a;
            `PGS_ADDR_FAULT_A: s_nxt.rdata = {1'b0, ch_a.fault};  // see [R5]
            `PGS_ADDR_SEL_B:   s_nxt.rdata = s_r.sel_b;
            `PGS_ADDR_FAULT_B: s_nxt.rdata = {1'b0, ch_b.fault};  // see [R10]
            default:           s_nxt.rdata = `PGS_RD_UNMAPPED;
        endcase
    end

    // top state register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= S_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // channel a wiring
    assign ch_a.sel    = s_r.sel_a;                               // see [R1]
    assign ch_a.good   = good;
    assign ch_a.clr    = wr_fault_a ? reg_wdata_i[`PGS_SRC_N-1:0] : `PGS_FAULT_RESET; // see [R7]
    assign ch_a.gating = s_r.ctrl[`PGS_CTL_GATE_A];               // see [R9]
    assign ch_a.pol    = s_r.ctrl[`PGS_CTL_POL_A];                // see [R11]

    // channel b wiring
    assign ch_b.sel    = s_r.sel_b;                               // see [R2] [R3]
    assign ch_b.good   = good;
    assign ch_b.clr    = wr_fault_b ? reg_wdata_i[`PGS_SRC_N-1:0] : `PGS_FAULT_RESET; // see [R10]
    assign ch_b.gating = s_r.ctrl[`PGS_CTL_GATE_B];
    assign ch_b.pol    = s_r.ctrl[`PGS_CTL_POL_B];                // see [R11]

    pgs_chan #(
        .DLY_CYC (RISE_DELAY_CYC)
    ) u_chan_a (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .c        (ch_a)
    );

    pgs_chan #(
        .DLY_CYC (RISE_DELAY_CYC)
    ) u_chan_b (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .c        (ch_b)
    );

    // outputs
    assign reg_rdata_o        = s_r.rdata;
    assign power_good_out_a_o = ch_a.pg;
    assign power_good_out_b_o = ch_b.pg;

    property p_reserved_a;
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_addr_i == `PGS_ADDR_FAULT_A) |=> (reg_rdata_o[7] == 1'b0 && reg_rdata_o[6:0] == $past(ch_a.fault));
    endproperty
    a_reserved_a: assert property (p_reserved_a) else $error("fault a readback wrong"); // see [R5]

    property p_fault_b_read;
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_addr_i == `PGS_ADDR_FAULT_B) |=> (reg_rdata_o == {1'b0, $past(ch_b.fault)});
    endproperty
    a_fault_b_read: assert property (p_fault_b_read) else $error("fault b readback wrong"); // see [R10]

    property p_sel_a_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        (wr_sel_a && s_r.loaded) |=> (s_r.sel_a == $past(reg_wdata_i));
    endproperty
    a_sel_a_write: assert property (p_sel_a_write) else $error("select a not written"); // see [R1]

    property p_sel_b_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        (wr_sel_b && s_r.loaded) |=> (s_r.sel_b == $past(reg_wdata_i))
            ##1 ($past(reg_addr_i) != `PGS_ADDR_SEL_B || reg_rdata_o == $past(s_r.sel_b));
    endproperty
    a_sel_b_write: assert property (p_sel_b_write) else $error("select b not written"); // see [R2]

    property p_thermal_b;
        @(posedge clk_i) disable iff (!arst_n_i)
        (s_r.sel_b[`PGS_SRC_THERMAL] && s_r.sync2[`PGS_SRC_THERMAL])
            |=> (power_good_out_b_o == $past(s_r.ctrl[`PGS_CTL_POL_B]));
    endproperty
    a_thermal_b: assert property (p_thermal_b) else $error("thermal warning did not drop b"); // see [R3]

    property p_otp_load;
        @(posedge clk_i) disable iff (!arst_n_i)
        (!s_r.loaded) |=> (s_r.loaded && s_r.sel_a == $past(otp_sel_a_i) && s_r.sel_b == $past(otp_sel_b_i));
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("otp defaults not loaded"); // see [R8]

    property p_ctrl_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        (wr_ctrl && s_r.loaded) |=> (s_r.ctrl == $past(reg_wdata_i));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control not written"); // see [R9]

    property p_otp_ctrl;
        @(posedge clk_i) disable iff (!arst_n_i)
        (!s_r.loaded) |=> (s_r.ctrl == $past(otp_ctrl_i));
    endproperty
    a_otp_ctrl: assert property (p_otp_ctrl) else $error("control default not loaded"); // see [R8]

    property p_sel_a_read;
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_addr_i == `PGS_ADDR_SEL_A) |=> (reg_rdata_o == $past(s_r.sel_a));
    endproperty
    a_sel_a_read: assert property (p_sel_a_read) else $error("select a readback wrong"); // see [R1]

    property p_clear_a;
        @(posedge clk_i) disable iff (!arst_n_i)
        (wr_fault_a && (reg_wdata_i[`PGS_SRC_N-1:0] & good) != '0)
            |=> ((ch_a.fault & $past(reg_wdata_i[`PGS_SRC_N-1:0] & good)) == '0);
    endproperty
    a_clear_a: assert property (p_clear_a) else $error("fault a clear not honoured"); // see [R7]

    property p_refuse_a;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_fault_a |=> ((ch_a.fault & $past(ch_a.fault & ~good)) == $past(ch_a.fault & ~good));
    endproperty
    a_refuse_a: assert property (p_refuse_a) else $error("fault a cleared while invalid"); // see [R7]

    property p_clear_b;
        @(posedge clk_i) disable iff (!arst_n_i)
        (wr_fault_b && (reg_wdata_i[`PGS_SRC_N-1:0] & good) != '0)
            |=> ((ch_b.fault & $past(reg_wdata_i[`PGS_SRC_N-1:0] & good)) == '0);
    endproperty
    a_clear_b: assert property (p_clear_b) else $error("fault b clear not honoured"); // see [R10]

    property p_refuse_b;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_fault_b |=> ((ch_b.fault & $past(ch_b.fault & ~good)) == $past(ch_b.fault & ~good));
    endproperty
    a_refuse_b: assert property (p_refuse_b) else $error("fault b cleared while invalid"); // see [R10]

    property p_mask_a;
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> ((ch_a.fault & ~$past(ch_a.fault) & ~$past(s_r.sel_a[`PGS_SRC_N-1:0])) == '0);
    endproperty
    a_mask_a: assert property (p_mask_a) else $error("masked source set fault a"); // see [R1]

    property p_mask_b;
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> ((ch_b.fault & ~$past(ch_b.fault) & ~$past(s_r.sel_b[`PGS_SRC_N-1:0])) == '0);
    endproperty
    a_mask_b: assert property (p_mask_b) else $error("masked source set fault b"); // see [R2]
endmodule
`default_nettype wire

// File: hdl/pgs_placeholder_note.sv
// intentionally empty compile unit; no logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: testbench/pgs_top_tb.sv
// self-checking bench for the power-good selector top
`timescale 1ns/1ns
`default_nettype none
module pgs_top_tb;
    logic       clk_i;
    logic       arst_n_i;
    logic [6:0] ok;
    logic [7:0] reg_addr_i;
    logic       reg_wr_i;
    logic [7:0] reg_wdata_i;
    logic [7:0] reg_rdata_o;
    logic       pg_a;
    logic       pg_b;
    logic [7:0] rv;
    logic [7:0] otp_ctrl;
    logic [7:0] otp_sel_a;
    logic [7:0] otp_sel_b;
    int         failures;
    int         n_checks;

    // design under test with a short rise delay
    pgs_top #(.RISE_DELAY_CYC(4)) dut (
        .clk_i                   (clk_i),
        .arst_n_i                (arst_n_i),
        .thermal_warning_i       (~ok[6]),
        .analog_supply_monitor_i (ok[5]),
        .external_monitor_two_i  (ok[4]),
        .external_monitor_one_i  (ok[3]),
        .boost_good_i            (ok[2]),
        .buck_second_good_i      (ok[1]),
        .buck_first_good_i       (ok[0]),
        .otp_ctrl_i              (otp_ctrl),
        .otp_sel_a_i             (otp_sel_a),
        .otp_sel_b_i             (otp_sel_b),
        .reg_addr_i              (reg_addr_i),
        .reg_wr_i                (reg_wr_i),
        .reg_wdata_i             (reg_wdata_i),
        .reg_rdata_o             (reg_rdata_o),
        .power_good_out_a_o      (pg_a),
        .power_good_out_b_o      (pg_b)
    );

    // 50 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        tick(2);
        d = reg_rdata_o;
    endtask

    // pins change after an edge, outputs settle three edges later
    task automatic pins(input logic [6:0] v);
        @(posedge clk_i);
        ok <= v;
        tick(4);
    endtask

    task automatic t_reset;
        rd(8'h17, rv); chk8(rv, 8'h00);
        rd(8'h18, rv); chk8(rv, 8'h07);
        rd(8'h1a, rv); chk8(rv, 8'h3f);
        rd(8'h19, rv); chk8(rv, 8'h00);
        rd(8'h1b, rv); chk8(rv, 8'h00);
        rd(8'h30, rv); chk8(rv, 8'h00);
        chk1(pg_a, 1'b1);
        chk1(pg_b, 1'b1);
        $display("test reset done");
    endtask

    // selected and masked sources, sticky faults, refused clear
    task automatic t_select;
        pins(7'h7b);
        chk1(pg_a, 1'b0);
        chk1(pg_b, 1'b0);
        rd(8'h19, rv); chk8(rv, 8'h04);
        wr(8'h19, 8'h04);
        rd(8'h19, rv); chk8(rv, 8'h04);
        wr(8'h18, 8'h03);
        tick(2);
        chk1(pg_a, 1'b1);
        pins(7'h7f);
        wr(8'h19, 8'hff);
        rd(8'h19, rv); chk8(rv, 8'h00);
        wr(8'h18, 8'h07);
        wr(8'h1b, 8'hff);
        pins(7'h5f);
        chk1(pg_a, 1'b1);
        chk1(pg_b, 1'b0);
        rd(8'h19, rv); chk8(rv, 8'h00);
        rd(8'h1b, rv); chk8(rv, 8'h20);
        pins(7'h7f);
        wr(8'h1b, 8'hff);
        rd(8'h1b, rv); chk8(rv, 8'h00);
        $display("test select done");
    endtask

    // output a held inactive by a latched fault until cleared
    task automatic t_gate;
        wr(8'h17, 8'h04);
        pins(7'h7e);
        pins(7'h7f);
        chk1(pg_a, 1'b0);
        chk1(pg_b, 1'b1);
        rd(8'h19, rv); chk8(rv, 8'h01);
        wr(8'h19, 8'h01);
        tick(2);
        chk1(pg_a, 1'b1);
        wr(8'h17, 8'h00);
        wr(8'h1b, 8'hff);
        $display("test gate done");
    endtask

    // thermal warning masked, then selected for output b
    task automatic t_thermal;
        pins(7'h3f);
        chk1(pg_b, 1'b1);
        wr(8'h1a, 8'h7f);
        tick(2);
        chk1(pg_b, 1'b0);
        rd(8'h1b, rv); chk8(rv, 8'h40);
        rd(8'h19, rv); chk8(rv, 8'h00);
        wr(8'h1b, 8'h40);
        rd(8'h1b, rv); chk8(rv, 8'h40);
        pins(7'h7f);
        wr(8'h1b, 8'h40);
        rd(8'h1b, rv); chk8(rv, 8'h00);
        wr(8'h1a, 8'h3f);
        $display("test thermal done");
    endtask

    // delayed rise on b lands exactly four edges after the undelayed one on a
    task automatic t_delay;
        wr(8'h1a, 8'hbf);
        pins(7'h7d);
        chk1(pg_b, 1'b0);
        pins(7'h7f);
        chk1(pg_a, 1'b1);
        chk1(pg_b, 1'b0);
        tick(2);
        chk1(pg_b, 1'b0);
        tick(1);
        chk1(pg_b, 1'b1);
        wr(8'h1a, 8'h3f);
        wr(8'h19, 8'hff);
        wr(8'h1b, 8'hff);
        $display("test delay done");
    endtask

    // inverted polarity on both outputs
    task automatic t_pol;
        wr(8'h17, 8'h11);
        tick(2);
        chk1(pg_a, 1'b0);
        chk1(pg_b, 1'b0);
        pins(7'h7e);
        chk1(pg_a, 1'b1);
        chk1(pg_b, 1'b1);
        pins(7'h7f);
        wr(8'h17, 8'h00);
        $display("test polarity done");
    endtask

    // reset in mid-run: outputs low, faults cleared, new otp defaults taken
    task automatic t_rearm;
        otp_ctrl  <= 8'h01;
        otp_sel_a <= 8'h03;
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        tick(2);
        chk1(pg_a, 1'b0);
        chk1(pg_b, 1'b0);
        chk8(reg_rdata_o, 8'h00);
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        tick(4);
        chk1(pg_a, 1'b0);
        chk1(pg_b, 1'b1);
        rd(8'h17, rv); chk8(rv, 8'h01);
        rd(8'h18, rv); chk8(rv, 8'h03);
        rd(8'h19, rv); chk8(rv, 8'h00);
        rd(8'h1b, rv); chk8(rv, 8'h00);
        $display("test rearm done");
    endtask

    task automatic results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial begin
        failures    = 0;
        n_checks    = 0;
        arst_n_i    = 1'b0;
        ok          = 7'h7f;
        reg_addr_i  = 8'h00;
        reg_wr_i    = 1'b0;
        reg_wdata_i = 8'h00;
        otp_ctrl    = 8'h00;
        otp_sel_a   = 8'h07;
        otp_sel_b   = 8'h3f;
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        tick(5);
        t_reset;
        t_select;
        t_gate;
        t_thermal;
        t_delay;
        t_pol;
        t_rearm;
        results;
    end
endmodule
`default_nettype wire
